//--- verilog/printer_port_pkg.sv
// What this block does
// - reset: data outputs, strobe/feed/select high, restart low
// - config bit 6 inverts interrupt output
// - config bit 7 enables fifo, default off
// - fifo holds up to 83 bytes
// - count register bits 6..0 give bytes held
// - count bit 7 reads one when fifo disabled
// - count up per data write, down per byte taken
// - write to full fifo is dropped
// - fifo reset clears the byte count
// - fifo mode only after first strobe answered
package printer_port_pkg;
  // ==========================================
  // register offsets
  localparam logic [1:0] OFS_DATA   = 2'h0;  // parallel_data_port
  localparam logic [1:0] OFS_STATUS = 2'h1;  // printer_status
  localparam logic [1:0] OFS_CTRL   = 2'h2;  // pin_state_readback / output_setting
  localparam logic [1:0] OFS_CFG    = 2'h3;  // alt_function_config / fifo_byte_count
  // ==========================================
  // field positions
  localparam int CFG_POL_BIT    = 6;  // interrupt polarity
  localparam int CFG_FIFO_BIT   = 7;  // fifo enable
  localparam int CFG_SRC_BIT    = 3;  // handshake source busy
  localparam int CNT_STATE_BIT  = 7;  // fifo state in count register
  localparam int SET_STB_BIT    = 0;
  localparam int SET_FEED_BIT   = 1;
  localparam int SET_INIT_BIT   = 2;
  localparam int SET_SEL_BIT    = 3;
  localparam int SET_IEN_BIT    = 4;
  localparam int SET_DIR_BIT    = 5;
  // ==========================================
  // reset values and sizes
  localparam logic [7:0] CFG_RST = 8'h00;   // fifo disabled, normal polarity
  localparam logic [7:0] SET_RST = 8'h04;   // restart bit pattern, no strobe
  localparam int FIFO_DEPTH      = 83;
  localparam int STROBE_CYCLES   = 2;       // automatic strobe width, clocks
  // ==========================================
  // printer-side sequencing
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,  // waiting for a queued byte
    SEQ_STB  = 2'b01,  // strobe low
    SEQ_WAIT = 2'b10   // waiting for the printer to take it
  } seq_t;
endpackage : printer_port_pkg

//--- verilog/byte_skid.sv
`timescale 1ns/10ps
// two-entry buffer between fifo and printer sequencer
module byte_skid #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         clr,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] slot_r [2];    // storage
  logic [W-1:0] slot_nxt [2];
  logic [1:0]   cnt_r, cnt_nxt; // entries held
  logic         push, pop;
  assign in_ready  = (cnt_r != 2'd2);
  assign out_valid = (cnt_r != 2'd0);
  assign out_data  = slot_r[0];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  // ==========================================
  // next state: shift out at slot 0
  always_comb begin
    slot_nxt = slot_r;
    cnt_nxt  = cnt_r;
    if (clr) begin
      cnt_nxt = 2'd0;
    end else begin
      if (pop) begin
        slot_nxt[0] = slot_r[1];
      end
      if (push) begin
        slot_nxt[(pop ? cnt_r - 2'd1 : cnt_r) == 2'd0 ? 0 : 1] = in_data;
      end
      cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
  // register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r    <= 2'd0;
      slot_r[0] <= '0;
      slot_r[1] <= '0;
    end else begin
      cnt_r  <= cnt_nxt;
      slot_r <= slot_nxt;
    end
  end
endmodule : byte_skid

//--- verilog/printer_port_regs.sv
`timescale 1ns/10ps
// host register set and printer output fifo
module printer_port_regs #(
  parameter int DEPTH = printer_port_pkg::FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] addr,           // register select
  input  wire logic       wr_stb,         // one-cycle host write
  input  wire logic       rd_stb,         // one-cycle host read
  input  wire logic [7:0] wr_data,
  output logic [7:0]      rd_data,        // registered read answer
  input  wire logic [7:0] parallel_data_lines_in,
  output logic [7:0]      parallel_data_lines_out,
  output logic [7:0]      parallel_data_lines_oe,
  output logic            strobe_n,
  output logic            auto_feed_n,
  output logic            restart_n,
  output logic            select_in_n,
  output logic            int_out,
  input  wire logic       ack_n,
  input  wire logic       busy,
  input  wire logic       error_n,
  input  wire logic       no_media,
  input  wire logic       printer_selected
);
  import printer_port_pkg::*;
  localparam int CW = 7;
  // ==========================================
  // state
  logic [7:0]    mem_r [DEPTH];               // fifo storage
  logic [7:0]    cfg_r, cfg_nxt;              // alt_function_config
  logic [7:0]    set_r, set_nxt;              // output_setting
  logic [7:0]    pdo_r, pdo_nxt;              // data register
  logic [CW-1:0] count_r, count_nxt;          // bytes held
  logic [CW-1:0] pend_r, pend_nxt;            // bytes in storage, not yet buffered
  logic [7:0]    byte_r, byte_nxt;            // byte on the lines during a strobe
  logic [CW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;  // pointers
  logic          fmode_r, fmode_nxt;          // fifo mode active
  logic          armed_r, armed_nxt;          // first strobe issued
  logic          ack_d_r, busy_d_r;           // edge history
  logic          lint_r, lint_nxt;            // latched interrupt, active low
  logic [7:0]    rd_nxt;
  logic          stb_o, stb_nxt, int_nxt;
  seq_t          seq_r, seq_nxt;
  logic [1:0]    sc_r, sc_nxt;                // strobe width count
  logic [7:0]    oe_nxt;
  // ==========================================
  // events
  logic fifo_on, full, take, ack_fall, busy_fall, fifo_clr, push, pull;
  logic sk_ready, sk_valid;
  logic [7:0] sk_data;
  assign fifo_on   = cfg_r[CFG_FIFO_BIT];
  assign full      = (count_r == CW'(DEPTH));
  assign ack_fall  = ack_d_r && !ack_n;
  assign busy_fall = busy_d_r && !busy;
  assign take      = cfg_r[CFG_SRC_BIT] ? busy_fall : ack_fall;
  // restart low or fifo turned off empties the fifo
  assign fifo_clr  = !set_r[SET_INIT_BIT] || !fifo_on;
  assign push      = wr_stb && addr == OFS_DATA && fifo_on && !full;
  // count_r also covers buffered bytes, so only pend_r says what storage still holds
  assign pull      = fmode_r && pend_r != '0 && sk_ready;
  // ==========================================
  // two-entry buffer toward the printer
  byte_skid #(.W(8)) u_skid (
    .clk      (clk),
    .rst_b    (rst_b),
    .clr      (fifo_clr),
    .in_valid (pull),
    .in_ready (sk_ready),
    .in_data  (mem_r[rp_r]),
    .out_valid(sk_valid),
    .out_ready(seq_r == SEQ_IDLE && fmode_r),
    .out_data (sk_data)
  );
  // ==========================================
  // register and fifo next state
  always_comb begin
    cfg_nxt   = cfg_r;
    set_nxt   = set_r;
    pdo_nxt   = pdo_r;
    wp_nxt    = wp_r;
    rp_nxt    = rp_r;
    count_nxt = count_r;
    fmode_nxt = fmode_r;
    armed_nxt = armed_r;
    lint_nxt  = lint_r;
    rd_nxt    = rd_data;
    if (wr_stb) begin
      case (addr)
        OFS_DATA: begin
          if (!fifo_on) begin
            pdo_nxt = wr_data;
          end
        end
        OFS_CTRL: set_nxt = wr_data;
        OFS_CFG:  cfg_nxt = wr_data;
        default:  ;
      endcase
    end
    if (push) begin
      wp_nxt = (wp_r == CW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
    end
    if (pull) begin
      rp_nxt = (rp_r == CW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
    end
    // bytes held counts host writes in and printer takes out
    count_nxt = count_r + CW'(push) - CW'(take && fmode_r && count_r != '0);
    // storage level: in on host write, out when the buffer takes a byte
    pend_nxt  = pend_r + CW'(push) - CW'(pull);
    // strobe from the setting register arms the mode switch
    if (!fmode_r && set_r[SET_STB_BIT]) armed_nxt = 1'b1;
    if (fifo_on && armed_r && (ack_fall || busy_fall)) fmode_nxt = 1'b1;
    if (ack_fall) lint_nxt = 1'b0;            // set wins over read clear
    else if (rd_stb && addr == OFS_STATUS) lint_nxt = 1'b1;
    if (fifo_clr) begin
      wp_nxt    = '0;
      rp_nxt    = '0;
      count_nxt = '0;
      pend_nxt  = '0;
      fmode_nxt = 1'b0;
      armed_nxt = 1'b0;
    end
    if (rd_stb) begin
      case (addr)
        OFS_DATA:   rd_nxt = set_r[SET_DIR_BIT] ? parallel_data_lines_in : pdo_r;
        OFS_STATUS: rd_nxt = {fifo_on ? !full : !busy, ack_n, no_media,
                              printer_selected, error_n, lint_r, 2'b11};
        OFS_CTRL:   rd_nxt = {3'b111, set_r[SET_IEN_BIT], !select_in_n,
                              restart_n, !auto_feed_n, !strobe_n};
        OFS_CFG:    rd_nxt = {!fifo_on, count_r};
        default:    rd_nxt = 8'h00;
      endcase
    end
  end
  // ==========================================
  // printer sequencer and pin drive
  always_comb begin
    seq_nxt = seq_r;
    sc_nxt  = sc_r;
    stb_o   = 1'b0;
    byte_nxt = byte_r;
    case (seq_r)
      SEQ_IDLE: begin
        if (fmode_r && sk_valid) begin
          seq_nxt = SEQ_STB;
          sc_nxt  = 2'(STROBE_CYCLES - 1);
          byte_nxt = sk_data;  // latch it: the buffer head moves on at this edge
        end
      end
      SEQ_STB: begin
        stb_o = 1'b1;
        if (sc_r == '0) seq_nxt = SEQ_WAIT;
        else sc_nxt = sc_r - 1'b1;
      end
      SEQ_WAIT: if (take) seq_nxt = SEQ_IDLE;
      default:  seq_nxt = SEQ_IDLE;
    endcase
    if (fifo_clr) seq_nxt = SEQ_IDLE;
    stb_nxt = !(fmode_r ? stb_o : set_nxt[SET_STB_BIT]);
    int_nxt = (set_nxt[SET_IEN_BIT] && ack_n) ^ cfg_nxt[CFG_POL_BIT];
    oe_nxt  = set_nxt[SET_DIR_BIT] ? 8'h00 : 8'hFF;
  end
  // ==========================================
  // registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r   <= CFG_RST;
      set_r   <= SET_RST;
      pdo_r   <= 8'h00;
      wp_r    <= '0;
      rp_r    <= '0;
      count_r <= '0;
      pend_r  <= '0;
      byte_r  <= 8'h00;
      fmode_r <= 1'b0;
      armed_r <= 1'b0;
      lint_r  <= 1'b1;
      ack_d_r <= 1'b1;
      busy_d_r <= 1'b0;
      rd_data <= 8'h00;
      seq_r   <= SEQ_IDLE;
      sc_r    <= '0;
      strobe_n    <= 1'b1;
      auto_feed_n <= 1'b1;
      select_in_n <= 1'b1;
      restart_n   <= 1'b0;
      parallel_data_lines_oe  <= 8'hFF;
      parallel_data_lines_out <= 8'h00;
      int_out <= 1'b0;
    end else begin
      cfg_r   <= cfg_nxt;
      set_r   <= set_nxt;
      pdo_r   <= pdo_nxt;
      wp_r    <= wp_nxt;
      rp_r    <= rp_nxt;
      count_r <= count_nxt;
      pend_r  <= pend_nxt;
      byte_r  <= byte_nxt;
      fmode_r <= fmode_nxt;
      armed_r <= armed_nxt;
      lint_r  <= lint_nxt;
      ack_d_r <= ack_n;
      busy_d_r <= busy;
      rd_data <= rd_nxt;
      seq_r   <= seq_nxt;
      sc_r    <= sc_nxt;
      strobe_n    <= stb_nxt;
      auto_feed_n <= !set_nxt[SET_FEED_BIT];
      select_in_n <= !set_nxt[SET_SEL_BIT];
      restart_n   <= set_nxt[SET_INIT_BIT];
      parallel_data_lines_oe  <= oe_nxt;
      parallel_data_lines_out <= fmode_r ? byte_nxt : pdo_nxt;
      int_out <= int_nxt;
    end
  end
  // fifo storage, written in place
  always_ff @(posedge clk) begin
    if (push) mem_r[wp_r] <= wr_data;
  end
endmodule : printer_port_regs

//--- verif/line_printer_model.sv
`timescale 1ns/10ps
// ==========================================
// line printer: answers each strobe with busy and a 3-cycle ack pulse
module line_printer_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       strobe_n,
  input  wire logic [7:0] lines_out,
  input  wire logic [7:0] lines_oe,
  input  wire logic [7:0] stall,      // extra cycles before acknowledging
  output logic            ack_n,
  output logic            busy,
  output logic [7:0]      lines_in,
  output int              taken,      // strobes seen
  output logic [7:0]      got         // byte on the lines at the last strobe
);
  logic s_q;  // strobe one cycle ago
  int   dly;  // cycles left in the answer
  // released lines show the inverse, not a stale copy
  assign lines_in = (lines_oe == 8'hFF) ? lines_out : ~lines_out;
  // ack low 3 cycles, wider than the minimum ack pulse
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {s_q, ack_n, busy, dly, taken, got} <= {1'b1, 1'b1, 1'b0, 32'h0, 32'h0, 8'h00};
    end else begin
      s_q <= strobe_n;
      if (s_q && !strobe_n) begin
        busy  <= 1'b1;
        dly   <= stall + 5;
        taken <= taken + 1;
        got   <= lines_out;
      end else if (dly > 0) begin
        dly   <= dly - 1;
        ack_n <= (dly > 4) || (dly == 1);
        busy  <= (dly != 1);
      end
    end
  end
endmodule : line_printer_model

//--- verif/printer_port_regs_asserts.sv
`timescale 1ns/10ps
// ==========================================
// checker on the host strobes and printer pins
module printer_port_regs_asserts #(
  parameter int DEPTH = printer_port_pkg::FIFO_DEPTH
) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [1:0] addr,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] parallel_data_lines_oe,
  input wire logic       strobe_n,
  input wire logic       auto_feed_n,
  input wire logic       restart_n,
  input wire logic       select_in_n,
  input wire logic       int_out,
  input wire logic       ack_n
);
  import printer_port_pkg::*;
  logic en_r, pol_r, ien_r, init_r;  // mirrors of written control bits
  // track fifo enable, polarity, interrupt enable and restart bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) {en_r, pol_r, ien_r, init_r} <= 4'h1;
    else if (wr_stb && addr == OFS_CFG) {en_r, pol_r} <= wr_data[7:6];
    else if (wr_stb && addr == OFS_CTRL) {ien_r, init_r} <= {wr_data[4], wr_data[2]};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence count_rd; rd_stb && !wr_stb && addr == OFS_CFG; endsequence
  sequence quiet; (!wr_stb && $stable(ack_n))[*2]; endsequence
  reset_pins_a: assert property (disable iff (1'b0) !rst_b |-> strobe_n && auto_feed_n
    && select_in_n && !restart_n && parallel_data_lines_oe == 8'hFF && rd_data == 8'h00)
    else $error("pins wrong in reset");
  rdata_hold_a: assert property (!rd_stb |=> $stable(rd_data))
    else $error("read data moved");
  fifo_state_a: assert property (count_rd |=> rd_data[CNT_STATE_BIT] == !en_r)
    else $error("fifo state bit wrong");
  count_bound_a: assert property (count_rd |=> rd_data[6:0] <= DEPTH)
    else $error("count above depth");
  off_count_a: assert property (count_rd ##0 (!en_r && !$past(en_r)) |=> rd_data[6:0] == 7'h00)
    else $error("count not clear");
  manual_strobe_a: assert property (wr_stb && addr == OFS_CTRL && !en_r && wr_data[2]
    |=> strobe_n == !$past(wr_data[SET_STB_BIT])) else $error("strobe not manual");
  restart_follow_a: assert property (wr_stb && addr == OFS_CTRL |=> restart_n ==
    $past(wr_data[2]) && auto_feed_n == !$past(wr_data[1]) && select_in_n == !$past(wr_data[3]))
    else $error("control pins wrong");
  int_polarity_a: assert property (quiet |-> int_out == ((ien_r & ack_n) ^ pol_r))
    else $error("interrupt level wrong");
endmodule : printer_port_regs_asserts
bind printer_port_regs printer_port_regs_asserts #(.DEPTH(DEPTH)) chk_u (.clk, .rst_b, .addr,
  .wr_stb, .rd_stb, .wr_data, .rd_data, .parallel_data_lines_oe, .strobe_n, .auto_feed_n,
  .restart_n, .select_in_n, .int_out, .ack_n);

//--- verif/printer_port_fifo_registers_bench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end
// ==========================================
// bench: host tasks, printer model, scenario tasks
module printer_port_fifo_registers_bench;
  import printer_port_pkg::*;
  logic clk = 0, rst_b = 1, wr_stb = 0, rd_stb = 0;  // host side
  logic [1:0] addr = 2'h0;
  logic [7:0] wr_data = 8'h00, rd_data, pd_in, pd_out, pd_oe, stall = 8'h00, d, got;
  logic strobe_n, auto_feed_n, restart_n, select_in_n, int_out, ack_n, busy;
  int err_count = 0, checked = 0, taken, n, t0;
  always #12.5 clk = ~clk;
  printer_port_regs dut_u (.clk, .rst_b, .addr, .wr_stb, .rd_stb, .wr_data, .rd_data,
    .parallel_data_lines_in(pd_in), .parallel_data_lines_out(pd_out),
    .parallel_data_lines_oe(pd_oe), .strobe_n, .auto_feed_n, .restart_n, .select_in_n,
    .int_out, .ack_n, .busy, .error_n(1'b1), .no_media(1'b0), .printer_selected(1'b1));
  line_printer_model prn_u (.clk, .rst_b, .strobe_n, .lines_out(pd_out), .lines_oe(pd_oe),
    .stall, .ack_n, .busy, .lines_in(pd_in), .taken, .got);
  // one write strobe, held one edge
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk) {addr, wr_data, wr_stb} <= {a, v, 1'b1};
    @(posedge clk) wr_stb <= 1'b0;
  endtask : wr
  // one read strobe, answer taken after the next edge
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk) {addr, rd_stb} <= {a, 1'b1};
    @(posedge clk) rd_stb <= 1'b0;
    #1 v = rd_data;
  endtask : rd
  task automatic conclude();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // pins in reset, count register reads fifo off after reset
  task automatic t_reset();
    `CHK({strobe_n, auto_feed_n, select_in_n, restart_n, pd_oe}, 12'hEFF)
    @(posedge clk) rst_b <= 1'b1;
    rd(OFS_CFG, d);
    `CHK(d, 8'h80)
  endtask : t_reset
  // polarity both ways, plus a manual strobe with fifo off
  task automatic t_polarity();
    wr(OFS_CTRL, 8'h15);
    wr(OFS_CTRL, 8'h14);
    wr(OFS_CFG, 8'h40);
    repeat (12) @(posedge clk);
    `CHK(int_out, 1'b0)
    wr(OFS_CFG, 8'h00);
    repeat (6) @(posedge clk);
    `CHK(int_out, 1'b1)
  endtask : t_polarity
  // fill past full, clear by restart, clear by disable
  task automatic t_fill();
    wr(OFS_CFG, 8'h80);
    for (int i = 0; i <= FIFO_DEPTH; i++) wr(OFS_DATA, 8'(i));
    rd(OFS_CFG, d);
    `CHK(d, {1'b0, 7'(FIFO_DEPTH)})
    wr(OFS_CTRL, 8'h10);
    wr(OFS_CTRL, 8'h14);
    rd(OFS_CFG, d);
    `CHK(d, 8'h00)
    wr(OFS_DATA, 8'hA5);
    wr(OFS_CFG, 8'h00);
    rd(OFS_CFG, d);
    `CHK(d, 8'h80)
  endtask : t_fill
  // queue three bytes, start fifo mode, slow printer drains them
  task automatic t_drain();
    wr(OFS_CFG, 8'h80);
    for (int i = 0; i < 3; i++) wr(OFS_DATA, 8'h3C + 8'(i));
    rd(OFS_CFG, d);
    `CHK(d, 8'h03)
    stall <= 8'h06;
    t0 = taken;
    wr(OFS_CTRL, 8'h15);
    wr(OFS_CTRL, 8'h14);
    for (n = 0; n < 400 && d !== 8'h00; n++) rd(OFS_CFG, d);
    if (n == 400) begin
      err_count++;
      conclude();
    end else begin
      repeat (30) @(posedge clk);
      `CHK(taken, t0 + 4)
      `CHK(got, 8'h3E)
    end
  endtask : t_drain
  initial begin
    rst_b <= 1'b0;  // falling edge at time zero resets every flop except the fifo storage mem_r before the first clock
    repeat (2) @(posedge clk);
    t_reset();
    t_polarity();
    t_fill();
    t_drain();
    conclude();
  end
endmodule : printer_port_fifo_registers_bench
